// File: core/ctb_top.sv
// Register block: error counts, bit timing, buffer words two and three, interrupt
`timescale 1ns/1ps
module ctb_top (
  // Clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // From the protocol engine
  input  wire logic [7:0]  tx_error_count,
  input  wire logic [7:0]  rx_error_count,
  input  wire logic        frame_ide,
  input  wire logic        tx_req_event,
  // To the protocol engine
  output logic             time_quantum_tick,
  output logic      [2:0]  sjw_quanta,
  output logic      [5:0]  frame_eid_low,
  output logic             frame_remote,
  output logic      [3:0]  frame_dlc,
  output logic      [7:0]  data_byte0,
  output logic      [7:0]  data_byte1,
  // Interrupt
  output logic             irq
);
  logic [15:0] err_q;
  logic [7:0]  cfg_q;
  logic [15:0] w2_q;
  logic [15:0] w3_q;
  logic [0:0]  ist_q;
  logic [0:0]  imsk_q;
  logic        remote_q;
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic        wr_cfg;
  logic        wr_w2;
  logic        wr_w3;
  logic        wr_ist;
  logic        wr_imsk;

  ctb_tq_if tq_bus ();

  // Byte-lane merge of a 16-bit register with APB write strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    merge16 = old_v;
    if (strb[0])
      merge16[7:0] = wd[7:0];
    if (strb[1])
      merge16[15:8] = wd[15:8];
  endfunction : merge16

  localparam logic [7:0] TQ_PRE_MUL_W = 8'(ctb_pkg::TQ_PRE_MUL);

  // Quantum length in clocks for a given prescale field
  function automatic logic [7:0] tq_period(input logic [5:0] bit_rate_prescale);
    tq_period = 8'(TQ_PRE_MUL_W * ({2'b00, bit_rate_prescale} + 8'h01));
  endfunction : tq_period

  // Access decode; a frozen block holds the access phase by lowering pready
  assign acc     = psel && penable && ce;
  assign wr_en   = acc && pwrite;
  assign wr_cfg  = wr_en && (paddr == ctb_pkg::OFF_CFG);
  assign wr_w2   = wr_en && (paddr == ctb_pkg::OFF_W2);
  assign wr_w3   = wr_en && (paddr == ctb_pkg::OFF_W3);
  assign wr_ist  = wr_en && (paddr == ctb_pkg::OFF_IST);
  assign wr_imsk = wr_en && (paddr == ctb_pkg::OFF_IMSK);

  // Address hit check for the error answer
  always_comb
  begin
    case (paddr)
      ctb_pkg::OFF_ERR, ctb_pkg::OFF_CFG, ctb_pkg::OFF_W2, ctb_pkg::OFF_W3,
      ctb_pkg::OFF_IST, ctb_pkg::OFF_IMSK, ctb_pkg::OFF_VEC: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait answer while enabled, error on unmapped offsets
  assign pready  = ce;
  assign pslverr = acc && !hit;

  // Read mux, unused and unimplemented bits read zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      ctb_pkg::OFF_ERR:  prdata[15:0] = err_q;
      ctb_pkg::OFF_CFG:  prdata[7:0]  = cfg_q;
      ctb_pkg::OFF_W2:   prdata[15:0] = w2_q & ctb_pkg::W2_IMPL_MASK;
      ctb_pkg::OFF_W3:   prdata[15:0] = w3_q;
      ctb_pkg::OFF_IST:  prdata[0]    = ist_q[0];
      ctb_pkg::OFF_IMSK: prdata[0]    = imsk_q[0];
      ctb_pkg::OFF_VEC:  prdata[31:0] = {ctb_pkg::TXREQ_IVT_ADDR,
                                         ctb_pkg::TXREQ_IRQ_NUM,
                                         ctb_pkg::TXREQ_VECTOR};
      default:           prdata = 32'h0000_0000;
    endcase
  end

  // Error counts mirrored from the engine, read-only to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= ctb_pkg::ERR_RST;
    else if (ce)
    begin
      err_q[ctb_pkg::ERR_TX_LSB +: 8] <= tx_error_count;
      err_q[ctb_pkg::ERR_RX_LSB +: 8] <= rx_error_count;
    end
  end

  // Bit timing config one; only the low byte exists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= ctb_pkg::CFG_RST;
    else if (wr_cfg && pstrb[0])
      cfg_q <= pwdata[7:0];
  end

  // Fields handed to the quantum generator
  assign tq_bus.bit_rate_prescale = cfg_q[ctb_pkg::BRP_LSB +: ctb_pkg::BRP_W];
  assign tq_bus.resync_jump_width = cfg_q[ctb_pkg::SJW_LSB +: ctb_pkg::SJW_W];

  ctb_tq_gen u_tq (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tq      (tq_bus.gen)
  );

  assign time_quantum_tick = tq_bus.tick;
  assign sjw_quanta        = tq_bus.sjw_quanta;

  // Buffer words carry no reset; their contents are undefined until written
  always_ff @(posedge pclk)
  begin
    if (wr_w2)
      w2_q <= merge16(w2_q, pwdata, pstrb) & ctb_pkg::W2_IMPL_MASK;
    if (wr_w3)
      w3_q <= merge16(w3_q, pwdata, pstrb);
  end

  // Buffer word fields toward the engine; reserved bits are stored as written
  assign frame_eid_low = w2_q[ctb_pkg::W2_EID_LSB +: ctb_pkg::W2_EID_W];
  assign frame_dlc     = w2_q[ctb_pkg::W2_DLC_LSB +: ctb_pkg::W2_DLC_W];
  assign data_byte0    = w3_q[ctb_pkg::W3_B0_LSB +: 8];
  assign data_byte1    = w3_q[ctb_pkg::W3_B1_LSB +: 8];
  assign frame_remote  = remote_q;

  // Remote request only honoured for extended frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      remote_q <= 1'b0;
    else if (ce)
      remote_q <= frame_ide && w2_q[ctb_pkg::W2_RTR_BIT];
  end

  // Sticky request flag, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ist_q <= ctb_pkg::IST_RST;
    else if (ce)
    begin
      if (tx_req_event)
        ist_q[ctb_pkg::IRQ_TXREQ_BIT] <= 1'b1;
      else if (wr_ist && pstrb[0] && pwdata[ctb_pkg::IRQ_TXREQ_BIT])
        ist_q[ctb_pkg::IRQ_TXREQ_BIT] <= 1'b0;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imsk_q <= ctb_pkg::IMSK_RST;
    else if (wr_imsk && pstrb[0])
      imsk_q[0] <= pwdata[ctb_pkg::IRQ_TXREQ_BIT];
  end

  // Level interrupt while an enabled flag stands
  assign irq = |(ist_q & imsk_q);

  // Helper: clocks between quantum ticks and whether the prescale held still
  logic [7:0] gap_q;
  logic       stable_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q    <= 8'h00;
      stable_q <= 1'b0;
    end
    else if (ce)
    begin
      gap_q    <= time_quantum_tick ? 8'h01 : gap_q + 8'h01;
      stable_q <= wr_cfg ? 1'b0 : (time_quantum_tick ? 1'b1 : stable_q);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Checks on the visible behaviour
  a_err_mirror: assert property (ce |=> err_q == {$past(tx_error_count), $past(rx_error_count)})
    else $error("error count register does not follow the engine");

  a_err_read: assert property (acc && !pwrite && paddr == ctb_pkg::OFF_ERR
                               |-> prdata == {16'h0000, err_q})
    else $error("error count read returns wrong data");

  a_sjw_width: assert property (wr_cfg && pstrb[0] ##1 ce
                                |=> sjw_quanta == {1'b0, $past(pwdata[7:6], 2)} + 3'h1)
    else $error("jump width does not equal field plus one");

  a_tq_period: assert property (ce && time_quantum_tick && stable_q && !wr_cfg
                                |-> gap_q == tq_period(tq_bus.bit_rate_prescale))
    else $error("quantum period differs from two times prescale plus one");

  a_eid_store: assert property (wr_w2 && pstrb[1]
                                |=> frame_eid_low == $past(pwdata[15:10]))
    else $error("extended identifier bits not stored");

  a_remote_ext: assert property (ce && frame_ide && w2_q[ctb_pkg::W2_RTR_BIT] |=> frame_remote)
    else $error("remote request not taken for extended frame");

  a_remote_std: assert property (ce && !frame_ide |=> !frame_remote)
    else $error("remote bit honoured for standard frame");

  a_unimpl_zero: assert property (acc && !pwrite && paddr == ctb_pkg::OFF_W2
                                  |-> prdata[7:5] == 3'b000)
    else $error("unimplemented word two bits read nonzero");

  a_bytes_store: assert property (wr_w3 && pstrb[1:0] == 2'b11
                                  |=> data_byte0 == $past(pwdata[7:0])
                                      && data_byte1 == $past(pwdata[15:8]))
    else $error("data bytes not stored in their lanes");

  a_irq_sticky: assert property (ce && tx_req_event ##1 imsk_q[0] |-> irq)
    else $error("transmit request did not raise the interrupt");

  a_cfg_upper: assert property (acc && !pwrite && paddr == ctb_pkg::OFF_CFG
                                |-> prdata[31:8] == 24'h000000)
    else $error("upper timing bits read nonzero");

  // Main scenarios
  c_tick_slow: cover property (time_quantum_tick && tq_bus.bit_rate_prescale == 6'h3F);
  c_remote:    cover property (frame_remote);
  c_irq_clear: cover property (irq ##1 wr_ist ##1 !irq);
endmodule : ctb_top

// File: core/ctb_pkg.sv
// Constants for the CAN timing and message buffer field block
package ctb_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFF_ERR  = 8'h00;
  localparam logic [7:0] OFF_CFG  = 8'h04;
  localparam logic [7:0] OFF_W2   = 8'h08;
  localparam logic [7:0] OFF_W3   = 8'h0C;
  localparam logic [7:0] OFF_IST  = 8'h10;
  localparam logic [7:0] OFF_IMSK = 8'h14;
  localparam logic [7:0] OFF_VEC  = 8'h18;
  // Reset values
  localparam logic [15:0] ERR_RST  = 16'h0000;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [0:0]  IST_RST  = 1'h0;
  localparam logic [0:0]  IMSK_RST = 1'h0;
  // Error counter fields
  localparam int ERR_RX_LSB = 0;
  localparam int ERR_TX_LSB = 8;
  // Bit timing config one fields
  localparam int CFG_W      = 8;
  localparam int SJW_LSB    = 6;
  localparam int SJW_W      = 2;
  localparam int BRP_LSB    = 0;
  localparam int BRP_W      = 6;
  localparam int TQ_PRE_MUL = 2;
  // Buffer word two fields
  localparam int W2_EID_LSB = 10;
  localparam int W2_EID_W   = 6;
  localparam int W2_RTR_BIT = 9;
  localparam int W2_RB1_BIT = 8;
  localparam int W2_RB0_BIT = 4;
  localparam int W2_DLC_LSB = 0;
  localparam int W2_DLC_W   = 4;
  localparam logic [15:0] W2_IMPL_MASK = 16'hFF1F;
  // Buffer word three fields
  localparam int W3_B0_LSB = 0;
  localparam int W3_B1_LSB = 8;
  // Interrupt status and mask bit of the transmit data request
  localparam int IRQ_TXREQ_BIT = 0;
  // Vector location of the transmit data request interrupt
  localparam logic [7:0]  TXREQ_VECTOR   = 8'h4E;
  localparam logic [7:0]  TXREQ_IRQ_NUM  = 8'h46;
  localparam logic [15:0] TXREQ_IVT_ADDR = 16'h00A0;
endpackage : ctb_pkg

// File: core/ctb_tq_if.sv
// Carrier between the register block and the time quantum generator
`timescale 1ns/1ps
interface ctb_tq_if;
  logic [5:0] bit_rate_prescale;
  logic [1:0] resync_jump_width;
  logic       tick;
  logic [2:0] sjw_quanta;
  modport regs (output bit_rate_prescale, output resync_jump_width, input tick, input sjw_quanta);
  modport gen  (input bit_rate_prescale, input resync_jump_width, output tick, output sjw_quanta);
endinterface : ctb_tq_if

// File: core/ctb_tq_gen.sv
// Time quantum prescaler and jump width decode
`timescale 1ns/1ps
module ctb_tq_gen (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Settings and results
  ctb_tq_if.gen    tq
);
  logic [6:0] cnt_q;
  logic       tick_q;
  logic [2:0] sjw_q;

  // Last count of a quantum: two times (prescale plus one), minus one
  function automatic logic [6:0] last_count(input logic [5:0] bit_rate_prescale);
    last_count = {bit_rate_prescale, 1'b1};
  endfunction : last_count

  // Quantum counter, restarts early if the prescale shrinks mid count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      tick_q <= (cnt_q >= last_count(tq.bit_rate_prescale));
      if (cnt_q >= last_count(tq.bit_rate_prescale))
        cnt_q <= 7'h00;
      else
        cnt_q <= cnt_q + 7'h01;
    end
  end

  // Jump width in quanta is the field plus one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sjw_q <= 3'h1;
    else if (ce)
      sjw_q <= {1'b0, tq.resync_jump_width} + 3'h1;
  end

  assign tq.tick       = tick_q;
  assign tq.sjw_quanta = sjw_q;
endmodule : ctb_tq_gen

// File: tb/ctb_engine_model.sv
// Behavioural protocol engine that feeds counts, frame type and events
`timescale 1ns/1ps
module ctb_engine_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Settings from the bench
  input  wire logic [7:0] tx_set,
  input  wire logic [7:0] rx_set,
  input  wire logic       ide_set,
  input  wire logic       fire,
  // Towards the register block
  output logic      [7:0] tx_error_count,
  output logic      [7:0] rx_error_count,
  output logic            frame_ide,
  output logic            tx_req_event
);
  logic fire_q;

  // Counts and frame type change only on a clock edge, like the engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_error_count <= 8'h00;
      rx_error_count <= 8'h00;
      frame_ide      <= 1'b0;
      fire_q         <= 1'b0;
      tx_req_event   <= 1'b0;
    end
    else
    begin
      tx_error_count <= tx_set;
      rx_error_count <= rx_set;
      frame_ide      <= ide_set;
      fire_q         <= fire;
      tx_req_event   <= fire ^ fire_q; // One pulse per toggle of fire
    end
  end
endmodule : ctb_engine_model

// File: tb/test_ctb_top.sv
// Self-checking bench for the CAN timing and buffer field block
`timescale 1ns/1ps
module test_ctb_top;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  tx_set;
  logic [7:0]  rx_set;
  logic        ide_set;
  logic        fire;
  logic [7:0]  tx_error_count;
  logic [7:0]  rx_error_count;
  logic        frame_ide;
  logic        tx_req_event;
  logic        time_quantum_tick;
  logic [2:0]  sjw_quanta;
  logic [5:0]  frame_eid_low;
  logic        frame_remote;
  logic [3:0]  frame_dlc;
  logic [7:0]  data_byte0;
  logic [7:0]  data_byte1;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          err_total;
  int          checked;
  int          cycles;
  int          c;

  ctb_top u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .tx_error_count, .rx_error_count, .frame_ide, .tx_req_event,
    .time_quantum_tick, .sjw_quanta, .frame_eid_low, .frame_remote, .frame_dlc, .data_byte0,
    .data_byte1, .irq);

  ctb_engine_model u_eng (.pclk, .presetn, .tx_set, .rx_set, .ide_set, .fire, .tx_error_count,
    .rx_error_count, .frame_ide, .tx_req_event);

  // Free running clock, 4 ns period
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // One APB transfer; read data and error taken at the edge with pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdchk

  // Program a prescale value, skip two periods (the first possibly short), measure the third
  task automatic tq_check(input int bit_rate_prescale);
    int k;
    int n;
    apb(1'b1, ctb_pkg::OFF_CFG, 32'(bit_rate_prescale));
    n = 0;
    for (k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end
      while (time_quantum_tick !== 1'b1 && n < 300);
    end
    chk("quantum period", 32'(2 * (bit_rate_prescale + 1)), 32'(n));
    // Back onto the rising edge before the next stimulus
    @(posedge pclk);
  endtask : tq_check

  // Main sequence
  initial
  begin
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    tx_set = 8'h00;
    rx_set = 8'h00;
    ide_set = 1'b0;
    fire = 1'b0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ctb_pkg::OFF_ERR, 32'h0000_0000, "error counts at reset");
    rdchk(ctb_pkg::OFF_CFG, 32'h0000_0000, "timing at reset");
    chk("jump width at reset", 32'h1, 32'(sjw_quanta));
    tx_set <= 8'hA5;
    rx_set <= 8'h3C;
    apb(1'b1, ctb_pkg::OFF_ERR, 32'h0000_FFFF);
    rdchk(ctb_pkg::OFF_ERR, 32'h0000_A53C, "error counts");
    for (c = 0; c < 4; c++)
    begin
      apb(1'b1, ctb_pkg::OFF_CFG, 32'hFFFF_FF2A & ~32'hC0 | 32'(c << 6));
      rdchk(ctb_pkg::OFF_CFG, 32'h2A | 32'(c << 6), "timing");
      chk("jump width", 32'(c + 1), 32'(sjw_quanta));
    end
    tq_check(0);
    tq_check(5);
    tq_check(63);
    ide_set <= 1'b1;
    apb(1'b1, ctb_pkg::OFF_W2, 32'h0000_A6EB);
    rdchk(ctb_pkg::OFF_W2, 32'h0000_A60B, "word two");
    chk("eid low", 32'h29, 32'(frame_eid_low));
    chk("dlc", 32'hB, 32'(frame_dlc));
    chk("remote extended", 32'h1, 32'(frame_remote));
    ide_set <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("remote standard", 32'h0, 32'(frame_remote));
    @(posedge pclk);
    ide_set <= 1'b1;
    apb(1'b1, ctb_pkg::OFF_W2, 32'h0000_FC08);
    rdchk(ctb_pkg::OFF_W2, 32'h0000_FC08, "word two data frame");
    chk("remote data frame", 32'h0, 32'(frame_remote));
    chk("eid all ones", 32'h3F, 32'(frame_eid_low));
    apb(1'b1, ctb_pkg::OFF_W3, 32'hFFFF_1234);
    rdchk(ctb_pkg::OFF_W3, 32'h0000_1234, "word three");
    chk("byte 0", 32'h34, 32'(data_byte0));
    chk("byte 1", 32'h12, 32'(data_byte1));
    // Frozen block holds the access; a lane-one write lands once enabled
    ce <= 1'b0;
    pstrb <= 4'h2;
    @(negedge pclk);
    chk("ready while frozen", 32'h0, 32'(pready));
    fork
      apb(1'b1, ctb_pkg::OFF_W3, 32'h0000_BEEF);
      begin
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    pstrb <= 4'hF;
    rdchk(ctb_pkg::OFF_W3, 32'h0000_BE34, "word three lane one");
    chk("byte 1 lane", 32'hBE, 32'(data_byte1));
    apb(1'b1, ctb_pkg::OFF_IMSK, 32'h0000_0000);
    fire <= ~fire;
    rdchk(ctb_pkg::OFF_IST, 32'h0000_0001, "irq status");
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, ctb_pkg::OFF_IMSK, 32'h0000_0001);
    @(negedge pclk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b1, ctb_pkg::OFF_IST, 32'h0000_0001);
    @(negedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    rdchk(ctb_pkg::OFF_IST, 32'h0000_0000, "irq status cleared");
    rdchk(ctb_pkg::OFF_VEC, 32'h00A0_464E, "vector");
    chk("mapped error", 32'h0, 32'(err));
    // Reset in mid-run returns timing and mask to their reset values
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ctb_pkg::OFF_CFG, 32'h0000_0000, "timing after reset");
    chk("jump width after reset", 32'h1, 32'(sjw_quanta));
    rdchk(ctb_pkg::OFF_IMSK, 32'h0000_0000, "mask after reset");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped error", 32'h1, 32'(err));
    end_of_test();
  end
endmodule : test_ctb_top
